// file: src/smr_defs.svh
// Purpose: Offsets, field positions and reset values of the switch-monitor register bank
// Assumes: Included by bare name from the bank, result store and test modules
// Notes:   Definitions only
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH

// ==========================================================================
// Register offsets (word addresses on the register port)
`define SMR_ADDR_RES_18_19   6'h13
`define SMR_ADDR_RES_20_21   6'h14
`define SMR_ADDR_RES_22_23   6'h15
`define SMR_ADDR_RES_SUPPLY  6'h16
`define SMR_ADDR_CONFIG      6'h1a

// ==========================================================================
// Result word layout
`define SMR_RES_ODD_LSB      10
`define SMR_RES_ODD_MSB      19
`define SMR_RES_EVEN_LSB     0
`define SMR_RES_EVEN_MSB     9
`define SMR_RES_RESET        24'h000000

// ==========================================================================
// Main configuration fields
`define SMR_CFG_DIV_SEL      23
`define SMR_CFG_SELFCHK_EN   22
`define SMR_CFG_WET_MSB      21
`define SMR_CFG_WET_LSB      18
`define SMR_CFG_SUPPLY_EN    17
`define SMR_CFG_TCUT_SRC     16
`define SMR_CFG_DEBOUNCE_MSB 15
`define SMR_CFG_DEBOUNCE_LSB 14
`define SMR_CFG_TCUT_SINK    13
`define SMR_CFG_INT_CFG      12
`define SMR_CFG_TRIGGER      11
`define SMR_CFG_POLL_EN      10
`define SMR_CFG_CRC_TRIG     9
`define SMR_CFG_ACT_MSB      8
`define SMR_CFG_ACT_LSB      5
`define SMR_CFG_PERIOD_MSB   4
`define SMR_CFG_PERIOD_LSB   1
`define SMR_CFG_RESET_REQ    0
`define SMR_CFG_RESET        24'h000000

// ==========================================================================
// Supply divider factors
`define SMR_DIV_LOW          4'h3
`define SMR_DIV_HIGH         4'ha

`endif

// file: src/smr_pkg.sv
// Purpose: Types shared by the switch-monitor register bank
// Assumes: smr_defs.svh holds the numbers
// Notes:   Types only
package smr_pkg;
    // ======================================================================
    // Result channel index: three pairs of inputs plus supply and self-check
    typedef enum logic [2:0] {
        SMR_CH_IN18    = 3'h0,
        SMR_CH_IN19    = 3'h1,
        SMR_CH_IN20    = 3'h2,
        SMR_CH_IN21    = 3'h3,
        SMR_CH_IN22    = 3'h4,
        SMR_CH_IN23    = 3'h5,
        SMR_CH_SUPPLY  = 3'h6,
        SMR_CH_SELFCHK = 3'h7
    } smr_chan_t;

    typedef logic [9:0]  smr_value_t;   // One conversion result
    typedef logic [23:0] smr_word_t;    // One register word
endpackage : smr_pkg

// file: src/smr_reg_bank.sv
// Purpose: Result and main configuration registers of the switch monitor
// Assumes: Register port driven by the serial front end on the same clock
// Notes:   One-cycle registered read answer; unmapped reads return zero
`timescale 1ns/1ns
`default_nettype none
`include "smr_defs.svh"
module smr_reg_bank
    import smr_pkg::*;
(
    input  wire logic       clk_in,            // 10 MHz system clock
    input  wire logic       reset_n_in,        // Asynchronous reset, active low
    input  wire logic [5:0] reg_addr_in,       // Register address
    input  wire logic       reg_wr_in,         // Write strobe
    input  wire logic       reg_rd_in,         // Read strobe
    input  wire logic [23:0] reg_wdata_in,     // Write data
    output logic [23:0]     reg_rdata_out,     // Read data
    output logic            reg_rvalid_out,    // Read data valid pulse
    input  wire logic       conv_valid_in,     // Conversion result strobe
    input  wire logic [2:0] conv_chan_in,      // Conversion channel
    input  wire logic [9:0] conv_value_in,     // Conversion value
    input  wire logic       poll_end_in,       // Polling cycle end pulse
    output logic            supply_meas_req_out, // Start supply measurement
    output logic            selfcheck_req_out, // Start converter self-check
    output logic [3:0]      supply_divider_out,  // Divide factor in use
    output logic [23:0]     config_out,        // Configuration fields to the core
    output logic            soft_reset_out     // Reset request pulse
);
    // ======================================================================
    // Reset release: two flip-flops
    logic rst_meta_reg;                        // First stage, read only by second
    logic rst_sync_reg;                        // Second stage
    logic rst_n;                               // Synchronised reset

    // Release is delayed two edges so no flop leaves reset on a marginal edge
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // ======================================================================
    // Address decode helper
    function automatic logic smr_hit(input logic [5:0] a, input logic [5:0] b);
        return a == b;
    endfunction : smr_hit

    // ======================================================================
    // Configuration and request state
    smr_word_t cfg_reg;                        // Main configuration
    smr_word_t cfg_next;
    smr_word_t cfg_rd_reg;                     // Config read path, zero if unselected
    smr_word_t cfg_rd_next;
    logic      rvalid_reg;
    logic      rvalid_next;
    logic      supply_req_reg;
    logic      supply_req_next;
    logic      self_req_reg;
    logic      self_req_next;
    logic      srst_reg;
    logic      srst_next;
    logic      res_hit;                        // Address names a result word

    smr_res_if res ();

    always_comb begin
        res_hit = smr_hit(reg_addr_in, `SMR_ADDR_RES_18_19) |
                  smr_hit(reg_addr_in, `SMR_ADDR_RES_20_21) |
                  smr_hit(reg_addr_in, `SMR_ADDR_RES_22_23) |
                  smr_hit(reg_addr_in, `SMR_ADDR_RES_SUPPLY);
        cfg_next    = cfg_reg;
        srst_next   = 1'b0;
        // Writes land only on configuration; result words ignore writes
        if (reg_wr_in && smr_hit(reg_addr_in, `SMR_ADDR_CONFIG)) begin
            cfg_next  = reg_wdata_in;
            // Reset request bit does not stick: it fires one pulse
            cfg_next[`SMR_CFG_RESET_REQ] = 1'b0;
            srst_next = reg_wdata_in[`SMR_CFG_RESET_REQ];
        end
        // Soft reset returns configuration to its reset value
        if (srst_reg) begin
            cfg_next = `SMR_CFG_RESET;
        end
        cfg_rd_next = 24'h000000;
        if (reg_rd_in && smr_hit(reg_addr_in, `SMR_ADDR_CONFIG)) begin
            cfg_rd_next = cfg_reg;
        end
        rvalid_next     = reg_rd_in;
        supply_req_next = poll_end_in && cfg_reg[`SMR_CFG_SUPPLY_EN];
        self_req_next   = poll_end_in && cfg_reg[`SMR_CFG_SELFCHK_EN];
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg        <= `SMR_CFG_RESET;
            cfg_rd_reg     <= 24'h000000;
            rvalid_reg     <= 1'b0;
            supply_req_reg <= 1'b0;
            self_req_reg   <= 1'b0;
            srst_reg       <= 1'b0;
        end else begin
            cfg_reg        <= cfg_next;
            cfg_rd_reg     <= cfg_rd_next;
            rvalid_reg     <= rvalid_next;
            supply_req_reg <= supply_req_next;
            self_req_reg   <= self_req_next;
            srst_reg       <= srst_next;
        end
    end

    // ======================================================================
    // Result store hookup
    assign res.wr_valid = conv_valid_in;
    assign res.wr_chan  = smr_chan_t'(conv_chan_in);   // 6: supply, 7: self
    assign res.wr_value = conv_value_in;
    assign res.rd_en    = reg_rd_in && res_hit;
    assign res.rd_pair  = 2'(reg_addr_in - `SMR_ADDR_RES_18_19);

    smr_result_store smr_result_store_inst (
        .clk_in   (clk_in),
        .rst_n_in (rst_n),
        .res      (res)
    );

    // ======================================================================
    // Outputs; only one read path is nonzero at a time
    assign reg_rdata_out       = res.rd_word | cfg_rd_reg;
    assign reg_rvalid_out      = rvalid_reg;
    assign supply_meas_req_out = supply_req_reg;
    assign selfcheck_req_out   = self_req_reg;
    assign supply_divider_out  = cfg_reg[`SMR_CFG_DIV_SEL] ? `SMR_DIV_HIGH : `SMR_DIV_LOW;
    assign config_out          = cfg_reg;
    assign soft_reset_out      = srst_reg;

    // ======================================================================
    // Checks
    property p_pair_layout;
        @(posedge clk_in) disable iff (!rst_n)
        (conv_valid_in && conv_chan_in == 3'h5) ##1 (reg_rd_in && reg_addr_in == 6'h15
            && !conv_valid_in) |=> reg_rdata_out[19:10] == $past(conv_value_in, 2);
    endproperty
    a_pair_layout: assert property (p_pair_layout) else $error("odd result misplaced");

    property p_reserved_zero;
        @(posedge clk_in) disable iff (!rst_n)
        reg_rvalid_out && !$past(smr_hit(reg_addr_in, 6'h1a)) |-> reg_rdata_out[23:20] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved result bits set");

    property p_unmapped_zero;
        @(posedge clk_in) disable iff (!rst_n)
        reg_rd_in && reg_addr_in == 6'h17 |=> reg_rvalid_out && reg_rdata_out == 24'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_selfchk_pos;
        @(posedge clk_in) disable iff (!rst_n)
        (conv_valid_in && conv_chan_in == 3'h7) ##1 (reg_rd_in && reg_addr_in == 6'h16
            && !conv_valid_in) |=> reg_rdata_out[19:10] == $past(conv_value_in, 2);
    endproperty
    a_selfchk_pos: assert property (p_selfchk_pos) else $error("self-check result misplaced");

    property p_supply_pos;
        @(posedge clk_in) disable iff (!rst_n)
        (conv_valid_in && conv_chan_in == 3'h6) ##1 (reg_rd_in && reg_addr_in == 6'h16
            && !conv_valid_in) |=> reg_rdata_out[9:0] == $past(conv_value_in, 2);
    endproperty
    a_supply_pos: assert property (p_supply_pos) else $error("supply result misplaced");

    property p_cfg_write;
        @(posedge clk_in) disable iff (!rst_n)
        reg_wr_in && reg_addr_in == 6'h1a && !srst_reg
            |=> config_out[23:1] == $past(reg_wdata_in[23:1]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_reset_req;
        @(posedge clk_in) disable iff (!rst_n)
        reg_wr_in && reg_addr_in == 6'h1a && reg_wdata_in[0]
            |=> soft_reset_out ##1 (config_out == 24'h0 && !soft_reset_out);
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("reset request misbehaved");

    property p_supply_req;
        @(posedge clk_in) disable iff (!rst_n)
        poll_end_in |=> supply_meas_req_out == $past(config_out[17]);
    endproperty
    a_supply_req: assert property (p_supply_req) else $error("supply request wrong");

    property p_divider;
        @(posedge clk_in) disable iff (!rst_n)
        supply_divider_out == (config_out[23] ? 4'ha : 4'h3);
    endproperty
    a_divider: assert property (p_divider) else $error("divider factor wrong");

    property p_selfchk_req;
        @(posedge clk_in) disable iff (!rst_n)
        selfcheck_req_out |-> $past(poll_end_in) && $past(config_out[22]);
    endproperty
    a_selfchk_req: assert property (p_selfchk_req) else $error("self-check request unexpected");
endmodule : smr_reg_bank
`default_nettype wire

// file: src/smr_res_if.sv
// Purpose: Carrier between bank top and result store
// Assumes: Single clock domain
// Notes:   Write side fills results, read side selects a pair word
`timescale 1ns/1ns
`default_nettype none
interface smr_res_if;
    import smr_pkg::*;
    logic       wr_valid;     // Store one conversion result
    smr_chan_t  wr_chan;      // Which channel it belongs to
    smr_value_t wr_value;     // The 10-bit result
    logic       rd_en;        // Fetch a pair word
    logic [1:0] rd_pair;      // 0: in18/19 .. 3: supply/self-check
    smr_word_t  rd_word;      // Registered pair word, zero when not fetched

    modport top   (output wr_valid, wr_chan, wr_value, rd_en, rd_pair, input rd_word);
    modport store (input wr_valid, wr_chan, wr_value, rd_en, rd_pair, output rd_word);
endinterface : smr_res_if
`default_nettype wire

// file: src/smr_result_store.sv
// Purpose: Holds the eight 10-bit results and forms the read-only pair words
// Assumes: Reset already synchronised by the top
// Notes:   Read word comes out of a register one cycle after rd_en
`timescale 1ns/1ns
`default_nettype none
`include "smr_defs.svh"
module smr_result_store
    import smr_pkg::*;
(
    input  wire logic clk_in,     // System clock
    input  wire logic rst_n_in,   // Synchronised reset, active low
    smr_res_if.store  res         // Result traffic
);
    // ======================================================================
    // Storage
    smr_value_t val_reg  [8];     // One slot per channel
    smr_value_t val_next [8];
    smr_word_t  rd_reg;           // Registered read word
    smr_word_t  rd_next;

    // Next values: newest conversion overwrites its slot
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            val_next[i] = val_reg[i];
        end
        if (res.wr_valid) begin
            val_next[res.wr_chan] = res.wr_value;
        end
        // Pair word: upper nibble reserved zero, odd above even
        rd_next = `SMR_RES_RESET;
        if (res.rd_en) begin
            rd_next[`SMR_RES_ODD_MSB:`SMR_RES_ODD_LSB]   = val_reg[{res.rd_pair, 1'b1}];
            rd_next[`SMR_RES_EVEN_MSB:`SMR_RES_EVEN_LSB] = val_reg[{res.rd_pair, 1'b0}];
        end
    end

    // Registers: all results clear on reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 8; i++) begin
                val_reg[i] <= 10'h000;
            end
            rd_reg <= 24'h000000;
        end else begin
            val_reg <= val_next;
            rd_reg  <= rd_next;
        end
    end

    assign res.rd_word = rd_reg;
endmodule : smr_result_store
`default_nettype wire

// file: test/smr_host_model.sv
// Purpose: Host controller model driving the register port of the bank
// Assumes: One clock; strobes are taken at the rising edge
// Notes:   Idle address and data show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module smr_host_model (
    input  wire logic        clk_in,    // System clock
    input  wire logic [23:0] rdata_in,  // Read data from the bank
    input  wire logic        rvalid_in, // Read answer strobe
    output var logic  [5:0]  addr_out,  // Register address
    output var logic         wr_out,    // Write strobe
    output var logic         rd_out,    // Read strobe
    output var logic  [23:0] wdata_out  // Write data
);
    // ======================================================
    // Bus idle at time zero
    initial begin
        addr_out  = 6'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 24'h000000;
    end

    // ======================================================
    // Bus cycles
    // Single-cycle write; afterwards the bus must not look valid
    task automatic write(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask : write

    // Single-cycle read; the answer is awaited for a bounded count
    task automatic read(input logic [5:0] a, output logic [23:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d  = 24'h000000;
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        for (n = 0; n < 4 && !ok; n++) begin
            #1;
            // Answer stands one cycle, so it is taken as soon as seen
            if (rvalid_in === 1'b1) begin
                d  = rdata_in;
                ok = 1'b1;
            end else begin
                @(posedge clk_in);
            end
        end
    endtask : read
endmodule : smr_host_model
`default_nettype wire

// file: test/smr_reg_bank_test.sv
// Purpose: Self-checking bench for the switch-monitor register bank
// Assumes: Host model owns the register port
// Notes:   Expected words are built from the pair layout
`timescale 1ns/1ns
`default_nettype none
`include "smr_defs.svh"
module smr_reg_bank_test;
    import smr_pkg::*;
    logic        clk_in;      // 100 ns clock
    logic        reset_n_in;  // Reset, active low
    logic [5:0]  addr;        // Register address
    logic        wr;          // Write strobe
    logic        rd;          // Read strobe
    logic [23:0] wdata;       // Write data
    logic [23:0] rdata;       // Read data
    logic        rvalid;      // Read answer
    logic        conv_valid;  // Conversion strobe
    logic [2:0]  conv_chan;   // Conversion slot
    logic [9:0]  conv_value;  // Conversion value
    logic        poll_end;    // Polling cycle end
    logic        sup_req;     // Supply measure request
    logic        chk_req;     // Self-check request
    logic [3:0]  divider;     // Divide factor
    logic [23:0] cfg;         // Configuration to core
    logic        soft_rst;    // Reset request pulse
    int          error_cnt;   // Mismatches
    int          check_count; // Comparisons
    int          k;           // Loop index
    // Distinct values; 3ffh shows the reserved bits stay clear
    smr_value_t  vals [8] = '{10'h3ff, 10'h001, 10'h200, 10'h155,
                              10'h2aa, 10'h0f0, 10'h30f, 10'h1c3};
    logic [23:0] pcfg [3] = '{24'h020000, 24'h400000, 24'h000000};

    smr_reg_bank smr_reg_bank_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .conv_valid_in(conv_valid),
        .conv_chan_in(conv_chan), .conv_value_in(conv_value), .poll_end_in(poll_end),
        .supply_meas_req_out(sup_req), .selfcheck_req_out(chk_req),
        .supply_divider_out(divider), .config_out(cfg), .soft_reset_out(soft_rst));
    smr_host_model smr_host_model_inst (.clk_in(clk_in), .rdata_in(rdata),
        .rvalid_in(rvalid), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

    // ======================================================
    // Checks and report
    task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic final_report();
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    // Read and compare; a missing answer ends the run
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] d;
        logic        ok;
        smr_host_model_inst.read(a, d, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: no read answer", $time);
            final_report();
        end
        cmp_word(d, exp);
    endtask : rd_chk
    // Polling end pulse; requests must follow one cycle later, once
    task automatic poll(input logic sup, input logic chk);
        @(posedge clk_in);
        poll_end <= 1'b1;
        @(posedge clk_in);
        poll_end <= 1'b0;
        #1;
        cmp_bit(sup_req, sup);
        cmp_bit(chk_req, chk);
        @(posedge clk_in);
        #1;
        cmp_bit(sup_req | chk_req, 1'b0);
    endtask : poll
    // Conversion, then a read of its word on the very next edge
    task automatic conv_rd(input logic [2:0] ch, input smr_value_t v,
                           input logic [5:0] a, input logic [23:0] exp);
        @(posedge clk_in);
        conv_valid <= 1'b1;
        conv_chan  <= ch;
        conv_value <= v;
        fork
            rd_chk(a, exp);
            begin
                @(posedge clk_in);
                conv_valid <= 1'b0;
            end
        join
    endtask : conv_rd
    // Reset held six cycles, first request on the fourth edge after
    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask : do_reset

    // ======================================================
    // Clock and stimulus
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        {error_cnt, check_count} = '0;
        {reset_n_in, conv_valid, conv_chan, conv_value, poll_end} = '0;
        do_reset();
        cmp_word({20'h0, divider}, {20'h0, `SMR_DIV_LOW});
        for (k = 0; k < 4; k++) rd_chk(6'(`SMR_ADDR_RES_18_19 + k), 24'h0);
        rd_chk(`SMR_ADDR_CONFIG, `SMR_CFG_RESET);
        // Back-to-back conversions into all eight slots
        for (k = 0; k < 8; k++) begin
            @(posedge clk_in);
            conv_valid <= 1'b1;
            conv_chan  <= 3'(k);
            conv_value <= vals[k];
        end
        @(posedge clk_in);
        conv_valid <= 1'b0;
        conv_value <= ~vals[7];
        for (k = 0; k < 4; k++)
            rd_chk(6'(`SMR_ADDR_RES_18_19 + k), {4'h0, vals[2*k+1], vals[2*k]});
        // Fresh result read on the next edge lands in its own half
        conv_rd(3'h5, 10'h0aa, `SMR_ADDR_RES_22_23, {4'h0, 10'h0aa, vals[4]});
        conv_rd(3'h6, 10'h123, `SMR_ADDR_RES_SUPPLY, {4'h0, vals[7], 10'h123});
        conv_rd(3'h7, 10'h3c5, `SMR_ADDR_RES_SUPPLY, {4'h0, 10'h3c5, 10'h123});
        // Result words ignore writes; unmapped reads give zero
        smr_host_model_inst.write(`SMR_ADDR_RES_20_21, 24'hffffff);
        rd_chk(`SMR_ADDR_RES_20_21, {4'h0, vals[3], vals[2]});
        rd_chk(6'h3f, 24'h0);
        rd_chk(6'h17, 24'h0);
        // Configuration read/write at both divider settings
        smr_host_model_inst.write(`SMR_ADDR_CONFIG, 24'hfffffe);
        rd_chk(`SMR_ADDR_CONFIG, 24'hfffffe);
        cmp_word({20'h0, divider}, {20'h0, `SMR_DIV_HIGH});
        smr_host_model_inst.write(`SMR_ADDR_CONFIG, 24'h555554);
        rd_chk(`SMR_ADDR_CONFIG, 24'h555554);
        cmp_word(cfg, 24'h555554);
        cmp_word({20'h0, divider}, {20'h0, `SMR_DIV_LOW});
        // Each enable alone, then neither
        for (k = 0; k < 3; k++) begin
            smr_host_model_inst.write(`SMR_ADDR_CONFIG, pcfg[k]);
            poll(pcfg[k][17], pcfg[k][22]);
        end
        // Reset request pulses once and clears the configuration
        smr_host_model_inst.write(`SMR_ADDR_CONFIG, 24'h800001);
        #1;
        cmp_bit(soft_rst, 1'b1);
        cmp_word(cfg, 24'h800000);
        @(posedge clk_in);
        #1;
        cmp_bit(soft_rst, 1'b0);
        cmp_word(cfg, 24'h0);
        // Mid-run reset clears configuration and results
        smr_host_model_inst.write(`SMR_ADDR_CONFIG, 24'h020000);
        do_reset();
        rd_chk(`SMR_ADDR_CONFIG, 24'h0);
        rd_chk(`SMR_ADDR_RES_SUPPLY, 24'h0);
        final_report();
    end
endmodule : smr_reg_bank_test
`default_nettype wire
